// [ppm_power_ctrl.sv]
// Power-down, power-saving, mode select and CRS/COL control with APB regs
//
// Summary of operation
// - Reset pin low or power-down bit: power down
// - Powered down: MAC-side outputs forced to zero
// - Powered down: twisted-pair transmit outputs tri-stated
// - Bit power-down keeps config, resets latching bits
// - Pin reset returns every register to default
// - 100M saving bit disables 100M modules in 10M
// - 10M saving bit disables 10M modules in 100M
// - Config-source pin picks autoneg pin or bit
// - Autoneg adopts highest common mode with partner
// - 100M mode enables 4B/5B, scrambling, MLT-3 path
// - 10M full duplex: no loopback, no SQE test
// - Full duplex: CRS on receive only, no COL
// - Half duplex: CRS on either, COL on overlap
`timescale 1ns/1ps
module ppm_power_ctrl
    import ppm_pkg::*;
#(
    parameter logic [3:0]  LOCAL_ABIL = ABIL_ALL,
    parameter int unsigned ADDR_W     = 8
) (
    input  wire logic              clock_in,
    input  wire logic              rst_n_in,
    input  wire logic              ce_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]       pwdata_in,
    output logic      [31:0]       prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    input  wire logic              hw_reset_pin_low_in,
    input  wire logic              autoneg_select_pin_in,
    input  wire logic              config_source_pin_in,
    input  wire logic [3:0]        partner_abil_in,
    input  wire logic              partner_valid_in,
    input  wire logic              tx_en_in,
    input  wire logic              rx_active_in,
    input  wire logic              rx_dv_raw_in,
    input  wire logic [3:0]        rxd_raw_in,
    input  wire logic              link_ok_in,
    input  wire logic              jabber_in,
    input  wire logic              rx_err_in,
    input  wire logic              tp_tx_pos_d_in,
    input  wire logic              tp_tx_neg_d_in,
    output logic                   crs_out,
    output logic                   col_out,
    output logic                   rx_dv_out,
    output logic      [3:0]        rxd_out,
    output logic                   tp_tx_pos_out,
    output logic                   tp_tx_pos_oe_out,
    output logic                   tp_tx_neg_out,
    output logic                   tp_tx_neg_oe_out,
    output logic                   mod100_en_out,
    output logic                   mod10_en_out,
    output logic                   enc100_en_out,
    output logic                   loopback_en_out,
    output logic                   sqe_test_en_out,
    output logic                   speed100_out,
    output logic                   full_duplex_out,
    output logic                   powered_down_out,
    output logic                   an_enable_out
);
    generate
        if (ADDR_W < IDX_W + 2) begin : g_chk_addr
            $error("ppm_power_ctrl: ADDR_W too small for register map");
        end
        if (WAKE_CYC >= (1 << WAKE_W)) begin : g_chk_wake
            $error("ppm_power_ctrl: WAKE_W too small for wake count");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers and reset-pin low filter

    logic [2:0]       pins_s;
    logic             rst_pin_n_s;
    logic             autoneg_select_pin_s;
    logic             cfg_sw_s;
    logic [2:0]       rst_low_cnt_q;
    logic             rst_req_q;

    ppm_pin_sync #(.WIDTH(3)) u_pin_sync (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .ce_in    (ce_in),
        .pin_in   ({hw_reset_pin_low_in, autoneg_select_pin_in,
                    config_source_pin_in}),
        .sync_out (pins_s)
    );
    assign rst_pin_n_s = pins_s[2];
    assign autoneg_select_pin_s     = pins_s[1];
    assign cfg_sw_s    = pins_s[0];

    // Short glitches are ignored; a reset needs the documented low time
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_low_cnt_q <= '0;
            rst_req_q     <= 1'b0;
        end else if (ce_in) begin
            if (rst_pin_n_s) begin
                rst_low_cnt_q <= '0;
                rst_req_q     <= 1'b0;
            end else if (rst_low_cnt_q != 3'(RST_MIN_CYC - 1)) begin
                rst_low_cnt_q <= rst_low_cnt_q + 3'h1;
            end else begin
                rst_req_q     <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Power state machine

    ppm_state_t       st_q;
    ppm_state_t       st_d;
    logic [WAKE_W-1:0] wake_cnt_q;
    logic [15:0]      ctrl_q;
    logic [15:0]      ext2_q;
    logic             ctrl_pd_w;
    logic             act_w;
    logic             pd_entry_w;

    assign ctrl_pd_w  = ctrl_q[CTRL_PD_BIT];
    assign act_w      = (st_q == ST_ACTIVE);
    assign pd_entry_w = act_w & ctrl_pd_w;

    // Reset pin wins over everything; the bit alone powers down too
    always_comb begin
        st_d = st_q;
        if (rst_req_q) begin
            st_d = ST_RESET;
        end else begin
            unique case (st_q)
                ST_RESET:  st_d = ST_WAKE;
                ST_WAKE:   if (wake_cnt_q == '0) begin
                    st_d = ctrl_pd_w ? ST_DOWN : ST_ACTIVE;
                end
                ST_DOWN:   if (!ctrl_pd_w) begin
                    st_d = ST_ACTIVE;
                end
                ST_ACTIVE: if (ctrl_pd_w) begin
                    st_d = ST_DOWN;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q       <= ST_RESET;
            wake_cnt_q <= WAKE_W'(WAKE_CYC - 1);
        end else if (ce_in) begin
            st_q <= st_d;
            if (st_q != ST_WAKE) begin
                wake_cnt_q <= WAKE_W'(WAKE_CYC - 1);
            end else if (wake_cnt_q != '0) begin
                wake_cnt_q <= wake_cnt_q - WAKE_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, answer registered

    logic             pready_q;
    logic             access_w;
    logic             do_wr_w;
    logic             do_rd_w;
    logic             hit_ctrl_w;
    logic             hit_ext2_w;
    logic             hit_stat_w;
    logic             hit_lat_w;
    logic             mapped_w;
    logic [31:0]      rd_mux_w;
    logic             ll_q;
    logic             lh_q;
    logic [LMX_W-1:0] lmx_q;
    logic             spd_w;
    logic             full_w;

    function automatic logic is_idx(input logic [ADDR_W-1:0] a,
                                    input int unsigned idx);
        is_idx = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
    endfunction

    assign hit_ctrl_w = is_idx(paddr_in, REG_CTRL_IDX);
    assign hit_ext2_w = is_idx(paddr_in, REG_EXT2_IDX);
    assign hit_stat_w = is_idx(paddr_in, REG_STAT_IDX);
    assign hit_lat_w  = is_idx(paddr_in, REG_LATCH_IDX);
    assign mapped_w   = hit_ctrl_w | hit_ext2_w | hit_stat_w | hit_lat_w;
    assign access_w   = psel_in & penable_in & ~pready_q;
    // Effects land on the edge where the master sees pready
    assign do_wr_w    = psel_in & penable_in & pready_q & pwrite_in;
    assign do_rd_w    = psel_in & penable_in & pready_q & ~pwrite_in;

    // Unmapped reads return zero with an error flag
    assign rd_mux_w =
        hit_ctrl_w ? {16'h0000, ctrl_q} :
        hit_ext2_w ? {16'h0000, ext2_q} :
        hit_stat_w ? {24'h000000, an_enable_out, mod10_en_out,
                      mod100_en_out, full_duplex_out, speed100_out,
                      2'(st_q), powered_down_out} :
        hit_lat_w  ? {24'h000000, lmx_q, 2'h0, lh_q, ll_q} :
        32'h00000000;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_q    <= 1'b0;
            prdata_out  <= '0;
            pslverr_out <= 1'b0;
        end else if (ce_in) begin
            pready_q    <= access_w;
            pslverr_out <= access_w & ~mapped_w;
            if (access_w) begin
                prdata_out <= pwrite_in ? 32'h00000000 : rd_mux_w;
            end
        end
    end
    assign pready_out = pready_q;

    ////////////////////////////////////////////////////////////////////
    // Configuration registers

    // Pin reset restores defaults; bit power-down leaves them alone
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_q <= CTRL_RST;
            ext2_q <= EXT2_RST;
        end else if (ce_in) begin
            if (rst_req_q) begin
                ctrl_q <= CTRL_RST;
                ext2_q <= EXT2_RST;
            end else if (do_wr_w && hit_ctrl_w) begin
                ctrl_q <= pwdata_in[15:0] & CTRL_WMASK;
            end else if (do_wr_w && hit_ext2_w) begin
                ext2_q <= pwdata_in[15:0] & EXT2_WMASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Latching status bits; a read re-arms them, a new event wins

    logic             rd_lat_w;
    logic             lat_clr_w;
    logic             ll_d;
    logic             lh_d;
    logic [LMX_W-1:0] lmx_d;

    assign rd_lat_w  = do_rd_w & hit_lat_w;
    // Held at defaults whenever the device is not running
    assign lat_clr_w = rst_req_q | pd_entry_w | ~act_w;
    assign ll_d  = rd_lat_w ? link_ok_in : (ll_q & link_ok_in);
    assign lh_d  = jabber_in | (lh_q & ~rd_lat_w);
    assign lmx_d = rd_lat_w ? LMX_W'(rx_err_in) :
                   (&lmx_q) ? lmx_q : lmx_q + LMX_W'(rx_err_in);

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ll_q  <= LL_DEF;
            lh_q  <= LH_DEF;
            lmx_q <= LMX_DEF;
        end else if (ce_in) begin
            ll_q  <= lat_clr_w ? LL_DEF  : ll_d;
            lh_q  <= lat_clr_w ? LH_DEF  : lh_d;
            lmx_q <= lat_clr_w ? LMX_DEF : lmx_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Mode resolution

    logic an_src_w;

    // Software mode when the source pin is high
    assign an_src_w = cfg_sw_s ? ctrl_q[CTRL_AN_BIT] : autoneg_select_pin_s;

    ppm_an_resolve #(.LOCAL_ABIL(LOCAL_ABIL)) u_an_resolve (
        .clock_in         (clock_in),
        .rst_n_in         (rst_n_in),
        .ce_in            (ce_in),
        .clr_in           (st_d != ST_ACTIVE), // Mode valid on entry
        .an_en_in         (an_src_w),
        .partner_abil_in  (partner_abil_in),
        .partner_valid_in (partner_valid_in),
        .man_speed100_in  (ctrl_q[CTRL_SPEED_BIT]),
        .man_full_in      (ctrl_q[CTRL_DUPLEX_BIT]),
        .speed100_out     (spd_w),
        .full_out         (full_w)
    );

    ////////////////////////////////////////////////////////////////////
    // Registered outputs; all but powered_down_out and an_enable_out forced quiet unless active

    logic save100_w;
    logic save10_w;

    assign save100_w = ext2_q[EXT2_SAVE100_BIT];
    assign save10_w  = ext2_q[EXT2_SAVE10_BIT];

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            crs_out          <= 1'b0;
            col_out          <= 1'b0;
            rx_dv_out        <= 1'b0;
            rxd_out          <= '0;
            tp_tx_pos_out    <= 1'b0;
            tp_tx_pos_oe_out <= 1'b0;
            tp_tx_neg_out    <= 1'b0;
            tp_tx_neg_oe_out <= 1'b0;
            mod100_en_out    <= 1'b0;
            mod10_en_out     <= 1'b0;
            enc100_en_out    <= 1'b0;
            loopback_en_out  <= 1'b0;
            sqe_test_en_out  <= 1'b0;
            speed100_out     <= 1'b0;
            full_duplex_out  <= 1'b0;
            powered_down_out <= 1'b1;
            an_enable_out    <= 1'b0;
        end else if (ce_in) begin
            crs_out          <= act_w & (rx_active_in |
                                (~full_w & tx_en_in));
            col_out          <= act_w & ~full_w & tx_en_in &
                                rx_active_in;
            rx_dv_out        <= act_w & rx_dv_raw_in;
            rxd_out          <= act_w ? rxd_raw_in : 4'h0;
            tp_tx_pos_out    <= act_w & tp_tx_pos_d_in;
            tp_tx_pos_oe_out <= act_w;
            tp_tx_neg_out    <= act_w & tp_tx_neg_d_in;
            tp_tx_neg_oe_out <= act_w;
            mod100_en_out    <= act_w & ~(save100_w & ~spd_w);
            mod10_en_out     <= act_w & ~(save10_w & spd_w);
            enc100_en_out    <= act_w & spd_w;
            loopback_en_out  <= act_w & ~spd_w & ~full_w;
            sqe_test_en_out  <= act_w & ~spd_w & ~full_w;
            speed100_out     <= spd_w;
            full_duplex_out  <= full_w;
            powered_down_out <= ~act_w;
            an_enable_out    <= an_src_w;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in || !ce_in);

    sequence seq_pd_entry;
        act_w && ctrl_pd_w && !rst_req_q && !do_wr_w;
    endsequence

    sequence seq_down_stay;
        (st_q == ST_DOWN) [*2];
    endsequence

    pd_entry_a: assert property (seq_pd_entry |=> st_q == ST_DOWN ##1
                                 powered_down_out)
        else $error("power-down bit did not power down");
    pd_outputs_a: assert property (powered_down_out |-> !crs_out &&
                                   !col_out && !rx_dv_out &&
                                   rxd_out == 4'h0)
        else $error("MAC-side output active while powered down");
    tp_hiz_a: assert property (powered_down_out |->
                               !tp_tx_pos_oe_out && !tp_tx_neg_oe_out)
        else $error("line driver enabled while powered down");
    keep_cfg_a: assert property (seq_pd_entry |=> ext2_q == $past(ext2_q)
                                 && lmx_q == LMX_DEF && lh_q == LH_DEF)
        else $error("power-down bit lost config or kept latches");
    rst_dflt_a: assert property (rst_req_q |=> ctrl_q == CTRL_RST &&
                                 ext2_q == EXT2_RST && ll_q == LL_DEF)
        else $error("pin reset did not restore defaults");
    save100_a: assert property (act_w |=> mod100_en_out ==
                                !($past(save100_w) && !$past(spd_w)))
        else $error("100M module enable wrong");
    save10_a: assert property (act_w |=> mod10_en_out ==
                               !($past(save10_w) && $past(spd_w)))
        else $error("10M module enable wrong");
    an_src_a: assert property (##1 an_enable_out == $past(cfg_sw_s ?
                               ctrl_q[CTRL_AN_BIT] : autoneg_select_pin_s))
        else $error("autoneg enable from wrong source");
    enc_mode_a: assert property (enc100_en_out |-> speed100_out &&
                                 !powered_down_out)
        else $error("100M coding enabled outside 100M mode");
    fd_sqe_a: assert property (full_duplex_out |-> !sqe_test_en_out &&
                               !loopback_en_out)
        else $error("loopback or SQE test in full duplex");
    fd_col_a: assert property (full_duplex_out |-> !col_out)
        else $error("collision shown in full duplex");
    hd_col_a: assert property (act_w && !full_w && tx_en_in &&
                               rx_active_in |=> col_out && crs_out)
        else $error("half-duplex overlap gave no collision");
    resume_a: assert property (seq_down_stay ##0 (!ctrl_pd_w &&
                               !rst_req_q) |=> act_w ##1
                               !powered_down_out)
        else $error("clearing power-down did not resume");

endmodule

// [ppm_pkg.sv]
// Constants, register map and types for the PHY power and mode control block
package ppm_pkg;

    // Register indices; byte address is four times the index
    localparam int unsigned REG_CTRL_IDX  = 0;
    localparam int unsigned REG_EXT2_IDX  = 19;
    localparam int unsigned REG_STAT_IDX  = 20;
    localparam int unsigned REG_LATCH_IDX = 21;
    localparam int unsigned IDX_W         = 6;

    // Control register fields and reset value
    localparam int unsigned CTRL_DUPLEX_BIT = 8;
    localparam int unsigned CTRL_PD_BIT     = 11;
    localparam int unsigned CTRL_AN_BIT     = 12;
    localparam int unsigned CTRL_SPEED_BIT  = 13;
    localparam logic [15:0] CTRL_RST        = 16'h3000;
    localparam logic [15:0] CTRL_WMASK      = 16'h3900;

    // Extended control 2 fields and reset value
    localparam int unsigned EXT2_SAVE100_BIT = 0;
    localparam int unsigned EXT2_SAVE10_BIT  = 1;
    localparam logic [15:0] EXT2_RST         = 16'h0000;
    localparam logic [15:0] EXT2_WMASK       = 16'h0003;

    // Latching status register layout and defaults
    localparam int unsigned LAT_LL_BIT  = 0;
    localparam int unsigned LAT_LH_BIT  = 1;
    localparam int unsigned LAT_MX_LSB  = 4;
    localparam int unsigned LMX_W       = 4;
    localparam logic        LL_DEF      = 1'b1;
    localparam logic        LH_DEF      = 1'b0;
    localparam logic [3:0]  LMX_DEF     = 4'h0;

    // Ability vector bit positions, highest performance first
    localparam int unsigned ABIL_100FD = 3;
    localparam int unsigned ABIL_100HD = 2;
    localparam int unsigned ABIL_10FD  = 1;
    localparam int unsigned ABIL_10HD  = 0;
    localparam logic [3:0]  ABIL_ALL   = 4'hF;

    // Timing
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned WAKE_TIME_NS  = 640;
    localparam int unsigned WAKE_CYC      =
        (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WAKE_W        = 7;
    localparam int unsigned RST_MIN_CYC   = 5;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_WAKE,
        ST_DOWN,
        ST_ACTIVE
    } ppm_state_t;

endpackage

// [ppm_pin_sync.sv]
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module ppm_pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clock_in,
    input  wire logic             rst_n_in,
    input  wire logic             ce_in,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    generate
        if (WIDTH < 1) begin : g_chk
            $error("ppm_pin_sync: WIDTH must be at least 1");
        end
    endgenerate

    // First stage feeds only the second stage
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else if (ce_in) begin
            meta_q   <= pin_in;
            sync_out <= meta_q;
        end
    end
endmodule

// [ppm_an_resolve.sv]
// Operating mode resolution: negotiated highest common mode or manual mode
`timescale 1ns/1ps
module ppm_an_resolve
    import ppm_pkg::*;
#(
    parameter logic [3:0] LOCAL_ABIL = ABIL_ALL
) (
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    input  wire logic       ce_in,
    input  wire logic       clr_in,
    input  wire logic       an_en_in,
    input  wire logic [3:0] partner_abil_in,
    input  wire logic       partner_valid_in,
    input  wire logic       man_speed100_in,
    input  wire logic       man_full_in,
    output logic            speed100_out,
    output logic            full_out
);
    logic [3:0] common_w;
    logic       pick_spd_w;
    logic       pick_full_w;
    logic       spd_d;
    logic       full_d;

    // Highest-performance mode both ends support; 10 half otherwise
    assign common_w    = LOCAL_ABIL & partner_abil_in;
    assign pick_spd_w  = common_w[ABIL_100FD] | common_w[ABIL_100HD];
    assign pick_full_w = common_w[ABIL_100FD] |
                         (~common_w[ABIL_100HD] & common_w[ABIL_10FD]);

    // Without a partner answer the link stays at the safest mode
    assign spd_d  = clr_in ? 1'b0 :
                    an_en_in ? (partner_valid_in & pick_spd_w) :
                    man_speed100_in;
    assign full_d = clr_in ? 1'b0 :
                    an_en_in ? (partner_valid_in & pick_full_w) :
                    man_full_in;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            speed100_out <= 1'b0;
            full_out     <= 1'b0;
        end else if (ce_in) begin
            speed100_out <= spd_d;
            full_out     <= full_d;
        end
    end
endmodule

// [ppm_mac_model.sv]
// MAC side partner: drives transmit and receive activity toward the PHY
`timescale 1ns/1ps
module ppm_mac_model (
    input  wire logic       clock_in,
    input  wire logic       tx_req_in,
    input  wire logic       rx_req_in,
    output logic            tx_en_out,
    output logic            rx_active_out,
    output logic            rx_dv_out,
    output logic      [3:0] rxd_out,
    output logic            link_ok_out
);
    // Idle receive data differs from frame data so leaks are visible
    always_ff @(posedge clock_in) begin
        tx_en_out     <= tx_req_in;
        rx_active_out <= rx_req_in;
        rx_dv_out     <= rx_req_in;
        rxd_out       <= rx_req_in ? 4'hA : 4'h5;
        link_ok_out   <= 1'b1;
    end
endmodule

// [tb_top.sv]
// Self-checking bench for the power and mode control block
`timescale 1ns/1ps
module tb_top;
    import ppm_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, hwr = 1;
    logic ans = 1, cfg = 1, pv = 0, txr = 0, rxr = 0, jab = 0, rxe = 0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0, prd;
    logic [3:0] pab = 4'h0, rxd, rxdo;
    logic rdy, err, tx, rxa, rdv, lok, crs, col, rdvo, tpp, tpn, oep, oen;
    logic m100, m10, enc, lb, sqe, s100, fd, pd, an;
    int error_cnt = 0, checks_done = 0, cyc = 0;
    logic [32:0] r;

    always #4 clk = ~clk;

    ppm_mac_model i_ppm_mac_model (.clock_in(clk), .tx_req_in(txr),
        .rx_req_in(rxr), .tx_en_out(tx), .rx_active_out(rxa),
        .rx_dv_out(rdv), .rxd_out(rxd), .link_ok_out(lok));

    ppm_power_ctrl i_ppm_power_ctrl (.clock_in(clk), .rst_n_in(rst_n),
        .ce_in(1'b1), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy),
        .pslverr_out(err), .hw_reset_pin_low_in(hwr),
        .autoneg_select_pin_in(ans), .config_source_pin_in(cfg),
        .partner_abil_in(pab), .partner_valid_in(pv), .tx_en_in(tx),
        .rx_active_in(rxa), .rx_dv_raw_in(rdv), .rxd_raw_in(rxd),
        .link_ok_in(lok), .jabber_in(jab), .rx_err_in(rxe),
        .tp_tx_pos_d_in(1'b0), .tp_tx_neg_d_in(1'b1), .crs_out(crs),
        .col_out(col), .rx_dv_out(rdvo), .rxd_out(rxdo),
        .tp_tx_pos_out(tpp), .tp_tx_pos_oe_out(oep), .tp_tx_neg_out(tpn),
        .tp_tx_neg_oe_out(oen), .mod100_en_out(m100), .mod10_en_out(m10),
        .enc100_en_out(enc), .loopback_en_out(lb), .sqe_test_en_out(sqe),
        .speed100_out(s100), .full_duplex_out(fd), .powered_down_out(pd),
        .an_enable_out(an));

    task automatic summarize();
        if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // A hang anywhere ends the run as a failure
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin error_cnt++; summarize(); end
    end

    task automatic chk(string n, logic [32:0] e, logic [32:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask

    // Holds the request until pready is seen at an edge; returns {err,data}
    // One idle edge follows so no signal is driven twice in a time step
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        psel <= 1; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk) pen <= 1;
        do @(posedge clk); while (rdy !== 1'b1);
        r = {err, prd};
        psel <= 0; pen <= 0;
        @(posedge clk);
    endtask

    task automatic settle(); repeat (4) @(posedge clk); endtask
    task automatic wake();
        for (int i = 0; i < 300 && pd !== 1'b0; i++) @(posedge clk);
        chk("pd", 0, pd);
    endtask

    // Register defaults and refused access
    task automatic sc_defaults();
        wake();
        apb(0, 8'h00, 0); chk("ctrl", 33'h3000, r);
        apb(0, 8'h04, 0); chk("unmap", 33'h100000000, r);
    endtask

    // Power saving bits against the running speed
    task automatic sc_save();
        apb(1, 8'h00, 32'h0000); apb(1, 8'h4C, 32'h0003); settle();
        chk("m10m", 2'b01, {m100, m10});
        apb(1, 8'h00, 32'h2000); settle();
        chk("m100m", 3'b101, {m100, m10, enc});
        apb(1, 8'h4C, 32'h0000); settle();
        chk("mnone", 2'b11, {m100, m10});
    endtask

    // Carrier and collision per duplex
    task automatic sc_duplex();
        apb(1, 8'h00, 32'h0000); txr <= 1; rxr <= 1; settle();
        chk("half", 4'hF, {crs, col, lb, sqe});
        rxr <= 0; apb(1, 8'h00, 32'h0100); settle();
        chk("fd_tx", 4'h0, {crs, col, lb, sqe});
        rxr <= 1; settle();
        chk("fd_rx", 4'h8, {crs, col, lb, sqe});
    endtask

    // Bit power-down keeps config, outputs forced, then resumes
    task automatic sc_pdown();
        jab <= 1; rxe <= 1; settle(); jab <= 0; rxe <= 0;
        apb(0, 8'h54, 0); chk("lat_set", 33'h43, r);
        jab <= 1; rxe <= 1; settle(); jab <= 0; rxe <= 0;
        apb(1, 8'h00, 32'h0900); settle();
        chk("pdout", 12'h800, {pd, crs, col, rdvo, rxdo, oep, oen, tpp,
            tpn});
        apb(0, 8'h00, 0); chk("keep", 33'h0900, r);
        apb(0, 8'h54, 0); chk("latch", 33'h1, r);
        apb(1, 8'h00, 32'h0100); wake();
        chk("resume", 6'h37, {fd, crs, col, oep, oen, tpn});
        txr <= 0; rxr <= 0;
    endtask

    // Autoneg source pin and highest common mode
    task automatic sc_autoneg();
        apb(1, 8'h00, 32'h1000); pv <= 1; pab <= 4'h3; settle();
        chk("an10", 3'b101, {an, s100, fd});
        pab <= 4'hF; settle();
        chk("an100", 3'b111, {an, s100, fd});
        cfg <= 0; ans <= 0; settle();
        chk("anpin0", 0, an);
        ans <= 1; settle();
        chk("anpin1", 1, an);
        cfg <= 1;
    endtask

    // Pin reset held past its minimum restores the ctrl and ext2 defaults
    task automatic sc_pinreset();
        apb(1, 8'h4C, 32'h0003);
        hwr <= 0; repeat (10) @(posedge clk);
        chk("pinpd", 1, pd);
        hwr <= 1; wake();
        apb(0, 8'h4C, 0); chk("ext2", 33'h0, r);
        apb(0, 8'h00, 0); chk("ctrl2", 33'h3000, r);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1;
        sc_defaults();
        sc_save();
        sc_duplex();
        sc_pdown();
        sc_autoneg();
        sc_pinreset();
        summarize();
    end
endmodule
